//--- hw/pbrx_defines.svh
`ifndef PBRX_DEFINES_SVH
`define PBRX_DEFINES_SVH

// Register window bases (one 16-bit register per address)
`define PBRX_CTRL_BASE   14'h0340
`define PBRX_ERR_BASE    14'h0360

// Control register field positions
`define PBRX_START_BIT   0
`define PBRX_CLEAR_BIT   1

// Reset values and limits
`define PBRX_CTRL_RST    2'h0
`define PBRX_CNT_RST     16'h0000
`define PBRX_CNT_MAX     16'hFFFF
`define PBRX_BITCNT_RST  11'h000
`define PBRX_RDATA_RST   16'h0000

`endif

//--- hw/pbrx_lane.sv
`timescale 1ns/10ps
`include "pbrx_defines.svh"

module pbrx_lane (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        counter_clear,
    input  wire logic        test_run,
    input  wire logic        in_window,
    input  wire logic        sample,
    input  wire logic        rx_bit,
    input  wire logic        expected_bit,
    output logic [15:0]      error_count
);

    pbrx_pkg::pbrx_lane_s state_ff;
    pbrx_pkg::pbrx_lane_s nxt_state;
    logic                 mismatch;

    // One error per differing bit inside the channel window
    assign mismatch = test_run && sample && in_window &&
                      (rx_bit != expected_bit);

    // Clear dominates; counting only while the test runs
    always_comb begin
        nxt_state = state_ff;
        if (counter_clear) begin
            nxt_state.count = `PBRX_CNT_RST;
        end else if (mismatch &&
                     state_ff.count != `PBRX_CNT_MAX) begin
            nxt_state.count = state_ff.count + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff.count <= `PBRX_CNT_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign error_count = state_ff.count;

    chk_clear_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        counter_clear |=> error_count == 16'h0000)
        else $error("count not zero after clear");

    chk_saturate_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        (error_count == 16'hFFFF && !counter_clear)
            |=> error_count == 16'hFFFF)
        else $error("saturated count moved");

    chk_stopped_stable: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!test_run && !counter_clear) |=> $stable(error_count))
        else $error("count changed while stopped");

    chk_mismatch_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        (mismatch && !counter_clear && error_count != 16'hFFFF)
            |=> error_count == $past(error_count) + 16'h0001)
        else $error("mismatch not counted once");

    chk_window_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!in_window && !counter_clear) [*2] |-> $stable(error_count))
        else $error("count moved outside window");

endmodule

//--- hw/pbrx_pkg.sv
package pbrx_pkg;

    // State of one stream's error counter
    typedef struct packed {
        logic [15:0] count;
    } pbrx_lane_s;

    // State of the register and timing logic
    typedef struct packed {
        logic [31:0]      sync1;
        logic [31:0]      sync2;
        logic             fp1;
        logic             fp2;
        logic [10:0]      bit_cnt;
        logic [31:0][1:0] ctrl;
        logic [15:0]      rdata;
    } pbrx_top_s;

endpackage

//--- hw/pbrx_receiver.sv
// Notes on behaviour
// - Clear bit holds counter and count at zero
// - Start bit enables the stream's comparison
// - Errors accumulate into readable count register
// - Error count saturates at FFFF, never wraps
// - Error count is read-only to software
// - Thirty-two independent stream register sets
// - Zero channel length means no comparison
`timescale 1ns/10ps
`include "pbrx_defines.svh"

module pbrx_receiver (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic [13:0]   cpu_addr,
    input  wire logic [15:0]   cpu_wdata,
    input  wire logic          cpu_wr,
    input  wire logic          cpu_rd,
    output logic [15:0]        cpu_rdata,
    input  wire logic          ber_receiver_global_enable,
    input  wire logic          frame_pulse,
    input  wire logic          bit_tick,
    input  wire logic [31:0]   serial_input_stream,
    input  wire logic [31:0]   expected_bit,
    input  wire logic [255:0]  ber_start_channel,
    input  wire logic [287:0]  ber_length_bits
);

    localparam logic [13:0] CTRL_BASE = `PBRX_CTRL_BASE;
    localparam logic [13:0] ERR_BASE  = `PBRX_ERR_BASE;

    pbrx_pkg::pbrx_top_s state_ff;
    pbrx_pkg::pbrx_top_s nxt_state;

    logic        ctrl_hit;
    logic        err_hit;
    logic [4:0]  idx;
    logic [31:0] test_run;
    logic [31:0] clear_vec;
    logic [31:0] in_window;
    logic [31:0] zero_len;
    logic [15:0] lane_count [32];
    logic [15:0] sel_count;
    logic [7:0]  chan;

    // Both windows are 32 words long and 32-aligned
    assign ctrl_hit  = cpu_addr[13:5] == CTRL_BASE[13:5];
    assign err_hit   = cpu_addr[13:5] == ERR_BASE[13:5];
    assign idx       = cpu_addr[4:0];
    assign sel_count = lane_count[idx];
    assign chan      = state_ff.bit_cnt[10:3];

    // Per-stream run, clear and channel window decode
    always_comb begin
        logic [9:0] first;
        logic [9:0] last_x;
        logic [8:0] len;
        first  = 10'h000;
        last_x = 10'h000;
        len    = 9'h000;
        for (int i = 0; i < 32; i++) begin
            len    = ber_length_bits[i*9 +: 9];
            first  = {2'h0, ber_start_channel[i*8 +: 8]};
            last_x = first + {1'h0, len};
            zero_len[i]  = len == 9'h000;
            // Global enable is only a gate; software orders it first
            test_run[i]  = state_ff.ctrl[i][`PBRX_START_BIT] &&
                           ber_receiver_global_enable;
            clear_vec[i] = state_ff.ctrl[i][`PBRX_CLEAR_BIT];
            in_window[i] = !zero_len[i] &&
                           ({2'h0, chan} >= first) &&
                           ({2'h0, chan} < last_x);
        end
    end

    // Synchronisers, frame bit counter and register port
    always_comb begin
        nxt_state       = state_ff;
        nxt_state.sync1 = serial_input_stream;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.fp1   = frame_pulse;
        nxt_state.fp2   = state_ff.fp1;
        if (bit_tick) begin
            // Frame pulse marks bit 0 of channel 0
            if (state_ff.fp2) begin
                nxt_state.bit_cnt = `PBRX_BITCNT_RST;
            end else begin
                nxt_state.bit_cnt = state_ff.bit_cnt + 11'h001;
            end
        end
        // Reserved bits are dropped, so they always read zero
        if (cpu_wr && ctrl_hit) begin
            nxt_state.ctrl[idx] = cpu_wdata[1:0];
        end
        // Writes to the count window fall through unused
        if (cpu_rd) begin
            if (ctrl_hit) begin
                nxt_state.rdata = {14'h0000, state_ff.ctrl[idx]};
            end else if (err_hit) begin
                nxt_state.rdata = sel_count;
            end else begin
                nxt_state.rdata = `PBRX_RDATA_RST;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff.sync1   <= 32'h00000000;
            state_ff.sync2   <= 32'h00000000;
            state_ff.fp1     <= 1'b0;
            state_ff.fp2     <= 1'b0;
            state_ff.bit_cnt <= `PBRX_BITCNT_RST;
            state_ff.ctrl    <= {32{`PBRX_CTRL_RST}};
            state_ff.rdata   <= `PBRX_RDATA_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cpu_rdata = state_ff.rdata;

    // One counter per input stream
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_lane
            pbrx_lane u_lane (
                .clock         (clock),
                .rst_n         (rst_n),
                .counter_clear (clear_vec[g]),
                .test_run      (test_run[g]),
                .in_window     (in_window[g]),
                .sample        (bit_tick),
                .rx_bit        (state_ff.sync2[g]),
                .expected_bit  (expected_bit[g]),
                .error_count   (lane_count[g])
            );
        end
    endgenerate

    chk_zero_len_win: assert property (
        @(posedge clock) disable iff (!rst_n)
        (zero_len & in_window) == 32'h00000000)
        else $error("window open with zero length");

    chk_count_readback: assert property (
        @(posedge clock) disable iff (!rst_n)
        (cpu_rd && err_hit) |=> cpu_rdata == $past(sel_count))
        else $error("count read returned wrong value");

    chk_run_gate: assert property (
        @(posedge clock) disable iff (!rst_n)
        !ber_receiver_global_enable |-> test_run == 32'h00000000)
        else $error("stream ran without global enable");

    // Each write lands in the addressed stream's word only
    chk_ctrl_write: assert property (
        @(posedge clock) disable iff (!rst_n)
        (cpu_wr && ctrl_hit)
            |=> state_ff.ctrl[$past(idx)] == $past(cpu_wdata[1:0]))
        else $error("control write not stored");

    // Control bits change only through a control-window write
    chk_ctrl_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        !(cpu_wr && ctrl_hit) |=> $stable(state_ff.ctrl))
        else $error("control bits changed without write");

    // Count-window writes have no register to land in
    chk_count_wr_drop: assert property (
        @(posedge clock) disable iff (!rst_n)
        (cpu_wr && err_hit) |=> $stable(state_ff.ctrl))
        else $error("count window write reached control");

    // Reserved control bits always read back as zero
    chk_reserved_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        (cpu_rd && ctrl_hit) |=> cpu_rdata[15:2] == 14'h0000)
        else $error("reserved control bits read non-zero");

    // Addresses outside both windows read as zero
    chk_unmapped_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        (cpu_rd && !ctrl_hit && !err_hit) |=> cpu_rdata == 16'h0000)
        else $error("unmapped read not zero");

    // Read data stands until the next read strobe
    chk_rdata_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        !cpu_rd |=> $stable(cpu_rdata))
        else $error("read data moved without a read");

    // A seen frame pulse puts the counter on bit 0 of channel 0
    chk_frame_restart: assert property (
        @(posedge clock) disable iff (!rst_n)
        (bit_tick && state_ff.fp2) |=> state_ff.bit_cnt == 11'h000)
        else $error("frame pulse did not restart bit count");

    // Every other tick moves the window position one bit on
    chk_bit_advance: assert property (
        @(posedge clock) disable iff (!rst_n)
        (bit_tick && !state_ff.fp2)
            |=> state_ff.bit_cnt == $past(state_ff.bit_cnt) + 11'h001)
        else $error("bit count did not advance");

    // Stream bits reach the compare two clocks after the pin;
    // waits until the chain holds data taken after reset
    chk_sync_delay: assert property (
        @(posedge clock) disable iff (!rst_n)
        $past(rst_n, 2)
            |-> state_ff.sync2 == $past(serial_input_stream, 2))
        else $error("stream sync delay not two clocks");

    // Frame pulse sees the same two-clock delay as the data
    chk_frame_sync: assert property (
        @(posedge clock) disable iff (!rst_n)
        $past(rst_n, 2)
            |-> state_ff.fp2 == $past(frame_pulse, 2))
        else $error("frame pulse sync delay not two clocks");

endmodule

//--- tb/pbrx_stream_src.sv
`timescale 1ns/10ps

// Far-end stream source: one bit per clock, errors on demand
module pbrx_stream_src (
    input  wire logic        clock,
    input  wire logic [31:0] err_mask,
    output logic             bit_tick,
    output logic             frame_pulse,
    output logic [31:0]      stream,
    output logic [31:0]      expected
);
    logic [2:0]  pat_ff = 3'h0;
    logic [31:0] exp_d1 = 32'h0;
    logic [31:0] exp_d2 = 32'h0;

    // Expectation lags the pin two clocks, matching the input sync;
    // frame every 8 ticks keeps the bit position inside channel 0
    always @(posedge clock) begin
        pat_ff      <= pat_ff + 3'h1;
        bit_tick    <= 1'b1;
        frame_pulse <= (pat_ff == 3'h7);
        stream      <= {32{pat_ff[2]}} ^ err_mask;
        exp_d1      <= {32{pat_ff[2]}};
        exp_d2      <= exp_d1;
        expected    <= exp_d2;
    end
endmodule

//--- tb/per_stream_ber_receiver_tb.sv
`timescale 1ns/10ps

module per_stream_ber_receiver_tb;
    logic         clock = 1'b0;
    logic         rst_n = 1'b0;
    logic [13:0]  addr = 14'h0;
    logic [15:0]  wdata = 16'h0;
    logic         wr = 1'b0;
    logic         rd = 1'b0;
    logic [15:0]  rdata;
    logic         gen = 1'b0;
    logic         tick;
    logic         fp;
    logic [31:0]  pin;
    logic [31:0]  xbit;
    logic [31:0]  mask = 32'h0;
    logic [255:0] schan = 256'h0;
    logic [287:0] blen = 288'h0;
    int           failures = 0;
    int           check_count = 0;
    int           cyc = 0;

    // 10 MHz clock
    always #50 clock = ~clock;

    // Hang guard, sized for the saturation run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 75000) begin
            failures++;
            complete_run();
        end
    end

    pbrx_receiver dut (.clock(clock), .rst_n(rst_n), .cpu_addr(addr),
        .cpu_wdata(wdata), .cpu_wr(wr), .cpu_rd(rd), .cpu_rdata(rdata),
        .ber_receiver_global_enable(gen), .frame_pulse(fp),
        .bit_tick(tick), .serial_input_stream(pin), .expected_bit(xbit),
        .ber_start_channel(schan), .ber_length_bits(blen));

    pbrx_stream_src src (.clock(clock), .err_mask(mask), .bit_tick(tick),
        .frame_pulse(fp), .stream(pin), .expected(xbit));

    task automatic wreg(input logic [13:0] a, input logic [15:0] d);
        @(negedge clock);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock);
        wr = 1'b0;
    endtask

    // Read data is looked at once the strobe has gone
    task automatic rreg(input logic [13:0] a, input logic [15:0] e);
        @(negedge clock);
        addr = a;
        rd = 1'b1;
        @(negedge clock);
        rd = 1'b0;
        @(negedge clock);
        check_count++;
        if (rdata !== e) begin
            $display("ERROR reg %h expected %h seen %h", a, e, rdata);
            failures++;
        end
    endtask

    // Force n bit errors on the masked streams, then let them settle
    task automatic errs(input logic [31:0] m, input int n);
        @(negedge clock);
        mask = m;
        repeat (n) @(negedge clock);
        mask = 32'h0;
        repeat (6) @(negedge clock);
    endtask

    task automatic t_reset();
        rreg(14'h0340, 16'h0000);
        rreg(14'h0360, 16'h0000);
        rreg(14'h03FF, 16'h0000);
    endtask

    task automatic t_ctrl();
        wreg(14'h0343, 16'hFFFF);
        rreg(14'h0343, 16'h0003);
        rreg(14'h0344, 16'h0000);
        wreg(14'h0343, 16'h0000);
    endtask

    task automatic t_count();
        gen = 1'b1;
        wreg(14'h0343, 16'h0001);
        wreg(14'h0345, 16'h0001);
        wreg(14'h0347, 16'h0001);
        errs(32'h4000_00A8, 10);
        rreg(14'h0363, 16'h000A);
        rreg(14'h0365, 16'h0000);
        rreg(14'h0367, 16'h0000);
        rreg(14'h037E, 16'h0000);
        wreg(14'h0363, 16'h1234);
        rreg(14'h0363, 16'h000A);
    endtask

    task automatic t_stop_clear();
        wreg(14'h0343, 16'h0000);
        errs(32'h0000_0008, 5);
        rreg(14'h0363, 16'h000A);
        wreg(14'h0343, 16'h0003);
        errs(32'h0000_0008, 5);
        rreg(14'h0363, 16'h0000);
        gen = 1'b0;
        wreg(14'h0343, 16'h0001);
        errs(32'h0000_0008, 4);
        rreg(14'h0363, 16'h0000);
        gen = 1'b1;
    endtask

    task automatic t_sat();
        errs(32'h0000_0008, 65540);
        rreg(14'h0363, 16'hFFFF);
    endtask

    task automatic complete_run();
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Stream 5 window misses channel 0, stream 7 has no length
    initial begin
        for (int i = 0; i < 32; i++) begin
            blen[i*9+:9] = 9'h001;
        end
        blen[5*9+:9] = 9'h0FF;
        blen[7*9+:9] = 9'h000;
        schan[5*8+:8] = 8'h01;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        t_reset();
        t_ctrl();
        t_count();
        t_stop_clear();
        t_sat();
        complete_run();
    end
endmodule
